// ---- logic/nibble_swap_xor_dir_load_unit.v ----
// datapath for nibble exchange, direction load and the two xor operations
// assumes a classic wishbone master on the core clock; the file registers
// live here as flip-flops and are also reachable over the bus
// an operation runs in the cycle after its command write is acknowledged,
// so software need not poll busy once one idle cycle separates two requests
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "nibble_swap_xor_regs.vh"

module nibble_swap_xor_dir_load_unit #(
   parameter WIDTH = 8,
   parameter FILE_DEPTH = 128,
   parameter FADDR_W = 7
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg [WIDTH-1:0] port_a_direction_o,
   output reg [WIDTH-1:0] port_b_direction_o,
   output reg [WIDTH-1:0] port_c_direction_o,
   output reg [WIDTH-1:0] accumulator_o,
   output reg zero_flag_o
);

   // ======================================================================
   // register map: one 32-bit word each, 8-bit data in byte lane 0 except 0x00 and 0x0c
   //   0x00 command: op [1:0], destination [2], operand [15:8]
   //        a lane 0 write launches the operation; lane 1 alone stages
   //        a new operand without running anything
   //   0x04 accumulator, read and write
   //   0x08 status: zero [0] read and write, bad operand [1] sticky,
   //        write one to clear, busy [2] read only
   //   0x0c direction registers, read only: a [7:0], b [15:8], c [23:16]
   //   0x10 file pointer for bus access, 7 bits
   //   0x14 file register at the pointer, read and write
   // unmapped offsets answer with zero and drop writes
   // limitation: the file pointer is the only way in from the bus, so a
   // table walk costs two transfers per entry

   // ======================================================================
   // state
   reg [WIDTH-1:0] file_q [0:FILE_DEPTH-1];
   reg [1:0] op_q;
   reg dest_q;
   reg [7:0] opnd_q;
   reg pend_q;
   reg badop_q;
   reg [FADDR_W-1:0] faddr_q;
   reg [31:0] rdata_d;

   wire req = wb_cyc_i & wb_stb_i;
   // a write lands at the edge where ack is high, as the master samples it
   wire wr_acc = req & wb_we_i & wb_ack_o;
   wire rd_issue = req & ~wb_ack_o;

   wire [FADDR_W-1:0] op_addr = opnd_q[FADDR_W-1:0];
   wire [WIDTH-1:0] op_file = file_q[op_addr];
   wire [WIDTH-1:0] alu_res;
   wire alu_zero;
   wire alu_zero_upd;

   // the two operations that read a file register and honour the destination
   function uses_file;
      input [1:0] op;
      begin
         uses_file = (op == `OP_NIBBLE_EXCHANGE) || (op == `OP_XOR_FILE);
      end
   endfunction

   // only the three selectors pass; the high operand bits must be clear too
   wire dir_ok = (opnd_q[7:3] == 5'h00) &&
                 (opnd_q[2:0] >= `DIR_SEL_A);
   wire exec_dir = pend_q & (op_q == `OP_DIRECTION_LOAD);
   wire to_file = pend_q & dest_q & uses_file(op_q);
   wire to_acc = (pend_q & ~dest_q & uses_file(op_q)) |
                 (pend_q & (op_q == `OP_XOR_IMMEDIATE));

   // ======================================================================
   // result unit
   swap_xor_alu #(
      .WIDTH(WIDTH)
   ) u_alu (
      .op_i(op_q),
      .acc_i(accumulator_o),
      .file_i(op_file),
      .literal_i(opnd_q[WIDTH-1:0]),
      .result_o(alu_res),
      .zero_upd_o(alu_zero_upd),
      .zero_o(alu_zero)
   );

   function sel_hit;
      input [7:0] adr;
      input [7:0] ofs;
      begin
         sel_hit = (adr == ofs);
      end
   endfunction

   // write strobes, true only at the edge where the master sees ack
   wire cmd_lo_wr = wr_acc & sel_hit(wb_adr_i, `OFS_CMD) & wb_sel_i[0];
   wire cmd_hi_wr = wr_acc & sel_hit(wb_adr_i, `OFS_CMD) & wb_sel_i[1];
   wire acc_wr = wr_acc & sel_hit(wb_adr_i, `OFS_ACC) & wb_sel_i[0];
   wire status_wr = wr_acc & sel_hit(wb_adr_i, `OFS_STATUS) & wb_sel_i[0];
   wire faddr_wr = wr_acc & sel_hit(wb_adr_i, `OFS_FADDR) & wb_sel_i[0];
   wire fdata_wr = wr_acc & sel_hit(wb_adr_i, `OFS_FDATA) & wb_sel_i[0];

   // ======================================================================
   // bus handshake and read data
   always @* begin
      rdata_d = 32'h0000_0000;
      case (wb_adr_i)
         `OFS_CMD: begin
            rdata_d[`CMD_OP_MSB:`CMD_OP_LSB] = op_q;
            rdata_d[`CMD_DEST_BIT] = dest_q;
            rdata_d[`CMD_OPND_MSB:`CMD_OPND_LSB] = opnd_q;
         end
         `OFS_ACC: begin
            rdata_d[WIDTH-1:0] = accumulator_o;
         end
         `OFS_STATUS: begin
            rdata_d[`ST_ZERO_BIT] = zero_flag_o;
            rdata_d[`ST_BADOP_BIT] = badop_q;
            rdata_d[`ST_BUSY_BIT] = pend_q;
         end
         `OFS_DIR: begin
            rdata_d[WIDTH-1:0] = port_a_direction_o;
            rdata_d[2*WIDTH-1:WIDTH] = port_b_direction_o;
            rdata_d[3*WIDTH-1:2*WIDTH] = port_c_direction_o;
         end
         `OFS_FADDR: begin
            rdata_d[FADDR_W-1:0] = faddr_q;
         end
         `OFS_FDATA: begin
            rdata_d[WIDTH-1:0] = file_q[faddr_q];
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         // ack one cycle after the request, dropped the cycle after
         // a request left up after ack is taken again once ack has dropped
         wb_ack_o <= rd_issue;
         if (rd_issue) begin
            wb_dat_o <= rdata_d;
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // ======================================================================
   // command capture
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         op_q <= `OP_NIBBLE_EXCHANGE;
         dest_q <= 1'b0;
         opnd_q <= 8'h00;
         pend_q <= 1'b0;
         faddr_q <= {FADDR_W{1'b0}};
      end else begin
         pend_q <= 1'b0;
         if (cmd_hi_wr) begin
            opnd_q <= wb_dat_i[`CMD_OPND_MSB:`CMD_OPND_LSB];
         end
         // writing the low byte launches the operation next edge;
         // the operand lane alone only stages a new operand
         if (cmd_lo_wr) begin
            op_q <= wb_dat_i[`CMD_OP_MSB:`CMD_OP_LSB];
            dest_q <= wb_dat_i[`CMD_DEST_BIT];
            pend_q <= 1'b1;
         end
         if (faddr_wr) begin
            faddr_q <= wb_dat_i[FADDR_W-1:0];
         end
      end
   end

   // ======================================================================
   // accumulator and zero flag
   // the datapath result wins over a bus write in the same cycle; by the
   // bus timing the two never meet, the order only keeps the logic total
   reg [WIDTH-1:0] acc_d;
   reg zero_d;

   always @* begin
      acc_d = accumulator_o;
      if (to_acc) begin
         acc_d = alu_res;
      end else if (acc_wr) begin
         acc_d = wb_dat_i[WIDTH-1:0];
      end
   end

   // only the xor operations touch the flag; swap and load leave it
   always @* begin
      zero_d = zero_flag_o;
      if (pend_q && alu_zero_upd) begin
         zero_d = alu_zero;
      end else if (status_wr) begin
         zero_d = wb_dat_i[`ST_ZERO_BIT];
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         accumulator_o <= `RST_ACC;
         zero_flag_o <= 1'b0;
      end else begin
         accumulator_o <= acc_d;
         zero_flag_o <= zero_d;
      end
   end

   // ======================================================================
   // bad operand flag: sticky, write one to clear, a new event wins
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         badop_q <= 1'b0;
      end else if (exec_dir && !dir_ok) begin
         badop_q <= 1'b1;
      end else if (status_wr && wb_dat_i[`ST_BADOP_BIT]) begin
         badop_q <= 1'b0;
      end
   end

   // ======================================================================
   // port direction registers; reset leaves every pin an input
   wire load_a = exec_dir & dir_ok & (opnd_q[2:0] == `DIR_SEL_A);
   wire load_b = exec_dir & dir_ok & (opnd_q[2:0] == `DIR_SEL_B);
   wire load_c = exec_dir & dir_ok & (opnd_q[2:0] == `DIR_SEL_C);

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_a_direction_o <= `RST_DIR;
      end else if (load_a) begin
         port_a_direction_o <= accumulator_o;
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_b_direction_o <= `RST_DIR;
      end else if (load_b) begin
         port_b_direction_o <= accumulator_o;
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_c_direction_o <= `RST_DIR;
      end else if (load_c) begin
         port_c_direction_o <= accumulator_o;
      end
   end

   // ======================================================================
   // file registers; the datapath write wins over a bus write
   reg file_we;
   reg [FADDR_W-1:0] file_wa;
   reg [WIDTH-1:0] file_wd;

   always @* begin
      file_we = 1'b0;
      file_wa = faddr_q;
      file_wd = wb_dat_i[WIDTH-1:0];
      if (to_file) begin
         file_we = 1'b1;
         file_wa = op_addr;
         file_wd = alu_res;
      end else if (fdata_wr) begin
         file_we = 1'b1;
      end
   end

   integer i;
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (i = 0; i < FILE_DEPTH; i = i + 1) begin
            file_q[i] <= `RST_FILE;
         end
      end else if (file_we) begin
         file_q[file_wa] <= file_wd;
      end
   end

endmodule
`default_nettype wire

// ---- logic/nibble_swap_xor_regs.vh ----
// constants for the nibble swap / xor / direction load datapath
// assumes a classic wishbone slave with 32-bit data and byte addresses
//
// How it works
// - swap puts low nibble high, high low
// - swap dest 0 to accumulator, 1 file
// - swap uses 7-bit address, flags untouched
// - direction load operand 5,6,7 picks A,B,C
// - direction load takes only 5..7, only bad operand flag
// - literal xor writes accumulator, only zero flag
// - file xor uses 7-bit address, zero flag
// - file xor dest 0 accumulator, 1 file
`ifndef NIBBLE_SWAP_XOR_REGS_VH
`define NIBBLE_SWAP_XOR_REGS_VH

// ======================================================================
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_ACC 8'h04
`define OFS_STATUS 8'h08
`define OFS_DIR 8'h0c
`define OFS_FADDR 8'h10
`define OFS_FDATA 8'h14

// ======================================================================
// command register fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 1
`define CMD_DEST_BIT 2
`define CMD_OPND_LSB 8
`define CMD_OPND_MSB 15

// ======================================================================
// operation codes
`define OP_NIBBLE_EXCHANGE 2'h0
`define OP_DIRECTION_LOAD 2'h1
`define OP_XOR_IMMEDIATE 2'h2
`define OP_XOR_FILE 2'h3

// ======================================================================
// status register fields
`define ST_ZERO_BIT 0
`define ST_BADOP_BIT 1
`define ST_BUSY_BIT 2

// ======================================================================
// direction load operands
`define DIR_SEL_A 3'h5
`define DIR_SEL_B 3'h6
`define DIR_SEL_C 3'h7

// ======================================================================
// reset values
`define RST_ACC 8'h00
`define RST_DIR 8'hff
`define RST_FILE 8'h00

`endif

// ---- logic/swap_xor_alu.v ----
// combinational result unit for the four datapath operations
// assumes operands are stable in the cycle the caller latches the result
`timescale 1ns/1ns
`default_nettype none
`include "nibble_swap_xor_regs.vh"

module swap_xor_alu #(
   parameter WIDTH = 8
) (
   input wire [1:0] op_i,
   input wire [WIDTH-1:0] acc_i,
   input wire [WIDTH-1:0] file_i,
   input wire [WIDTH-1:0] literal_i,
   output reg [WIDTH-1:0] result_o,
   output reg zero_upd_o,
   output reg zero_o
);

   // ======================================================================
   // helpers
   function [WIDTH-1:0] swap_nib;
      input [WIDTH-1:0] v;
      begin
         swap_nib = {v[WIDTH/2-1:0], v[WIDTH-1:WIDTH/2]};
      end
   endfunction

   function is_zero;
      input [WIDTH-1:0] v;
      begin
         is_zero = (v == {WIDTH{1'b0}});
      end
   endfunction

   // ======================================================================
   // operation select
   always @* begin
      result_o = acc_i;
      zero_upd_o = 1'b0;
      case (op_i)
         `OP_NIBBLE_EXCHANGE: begin
            result_o = swap_nib(file_i);
         end
         `OP_DIRECTION_LOAD: begin
            result_o = acc_i;
         end
         `OP_XOR_IMMEDIATE: begin
            result_o = acc_i ^ literal_i;
            zero_upd_o = 1'b1;
         end
         `OP_XOR_FILE: begin
            result_o = acc_i ^ file_i;
            zero_upd_o = 1'b1;
         end
         default: begin
            result_o = acc_i;
         end
      endcase
      zero_o = is_zero(result_o);
   end

endmodule
`default_nettype wire

// ---- dv/swap_unit_checker_assertions.sv ----
// checker for the swap / xor / direction load unit's ports
// assumes it is bound into nibble_swap_xor_dir_load_unit
`timescale 1ns/1ns
`default_nettype none
module swap_unit_checker (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] port_a_direction_o,
   input wire logic [7:0] port_b_direction_o,
   input wire logic [7:0] port_c_direction_o,
   input wire logic [7:0] accumulator_o,
   input wire logic zero_flag_o
);
   // ====================================================================
   // command launch seen at the ack edge; result shows two samples later
   wire logic cmd = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] & (wb_adr_i == 8'h00);
   wire logic [1:0] op = wb_dat_i[1:0];
   wire logic [7:0] opnd = wb_dat_i[15:8];
   wire logic dirok = (op == 2'h1) && (opnd >= 8'h05) && (opnd <= 8'h07);
   wire logic xz = (op == 2'h2) || ((op == 2'h3) && !wb_dat_i[2]);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not 0");
   a_dir_a_load: assert property ($past(cmd && dirok && opnd == 8'h05, 2) |->
      port_a_direction_o == $past(accumulator_o)) else $error("dir a wrong");
   a_dir_hold: assert property (!$past(cmd && dirok, 2) |-> $stable(port_a_direction_o)
      && $stable(port_b_direction_o) && $stable(port_c_direction_o)) else $error("dir moved");
   a_xor_imm: assert property ($past(cmd && op == 2'h2, 2) |-> accumulator_o ==
      ($past(accumulator_o) ^ $past(opnd, 2))) else $error("xor imm wrong");
   a_zero_match: assert property ($past(cmd && xz, 2) |->
      zero_flag_o == (accumulator_o == 8'h00)) else $error("zero wrong");
   a_flags_kept: assert property ($past(cmd && !op[1], 2) |-> $stable(zero_flag_o))
      else $error("zero moved");
   a_acc_kept_file: assert property ($past(cmd && op == 2'h3 && wb_dat_i[2], 2) |->
      $stable(accumulator_o)) else $error("acc moved");
   c_swap: cover property (cmd && op == 2'h0);
   c_dir: cover property (cmd && dirok);
   c_zero: cover property (zero_flag_o);
endmodule
bind nibble_swap_xor_dir_load_unit swap_unit_checker chk (.clk_i, .arst_n_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .port_a_direction_o, .port_b_direction_o, .port_c_direction_o, .accumulator_o,
   .zero_flag_o);
`default_nettype wire

// ---- dv/wb_host.sv ----
// bus master standing in for the core's decoder side
// assumes a classic wishbone slave; one idle cycle between requests
`timescale 1ns/1ns
`default_nettype none
module wb_host (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   end
   // ====================================================================
   // released address and data lines show the inverse so stale values never look valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {3'b000, ~a, 4'h0, ~d};
   endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the swap / xor / direction load unit
// assumes the unit acks one cycle after a request and executes next cycle
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic cyc, stb, we, ack, zf;
   logic [7:0] adr, pa, pb, pc, acc, a, f, k, r;
   logic [3:0] sel;
   logic [31:0] wd, rdat, q;
   logic [23:0] dirs = 24'hffffff;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   initial forever #20 clk_i = ~clk_i;
   wb_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
   nibble_swap_xor_dir_load_unit dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
      .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_direction_o(pa), .port_b_direction_o(pb),
      .port_c_direction_o(pc), .accumulator_o(acc), .zero_flag_o(zf));
   // ====================================================================
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      host.xfer(1'b1, ad, d, q);
   endtask
   task automatic rd(input logic [7:0] ad);
      host.xfer(1'b0, ad, 32'h0, q);
   endtask
   task automatic cmd(input logic [1:0] op, input logic dst, input logic [7:0] o);
      wr(8'h00, {16'h0, o, 5'h0, dst, op});
   endtask
   function automatic logic [7:0] swp(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      q = $urandom(32'ha5a5);
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      cmp("dir", 24'hffffff, {pc, pb, pa});
      for (int i = 0; i < 24; i++) begin
         a = $urandom;
         f = (i < 2) ? 8'h7f : $urandom & 8'h7f;
         k = (i == 1) ? a : $urandom;
         wr(8'h04, a);
         wr(8'h10, f);
         wr(8'h14, k);
         wr(8'h08, {31'h0, i[2]});
         cmd(2'h0, i[0], f);
         r = i[0] ? a : swp(k);
         rd(8'h04);
         cmp("swap acc", r, q[7:0]);
         rd(8'h14);
         cmp("swap file", i[0] ? swp(k) : k, q[7:0]);
         cmp("swap zero", i[2], zf);
         wr(8'h04, a);
         wr(8'h14, k);
         cmd(2'h3, i[1], f);
         rd(8'h04);
         cmp("xor file acc", i[1] ? a : a ^ k, q[7:0]);
         rd(8'h14);
         cmp("xor file f", i[1] ? a ^ k : k, q[7:0]);
         cmp("xor file zero", a == k, zf);
         k = (i == 2) ? a : $urandom;
         wr(8'h04, a);
         cmd(2'h2, i[0], k);
         rd(8'h04);
         cmp("xor imm acc", a ^ k, q[7:0]);
         cmp("xor imm zero", a == k, zf);
         cmp("acc pin", a ^ k, acc);
      end
      for (int s = 4; s < 9; s++) begin
         a = $urandom;
         wr(8'h04, a);
         wr(8'h08, {31'h0, s[0]});
         cmd(2'h1, 1'b0, s[7:0]);
         if (s > 4 && s < 8) dirs[(s - 5) * 8 +: 8] = a;
         rd(8'h0c);
         cmp("dir", dirs, q[23:0]);
         cmp("dir pins", dirs, {pc, pb, pa});
         cmp("dir zero", s[0], zf);
         rd(8'h08);
         cmp("bad operand", s < 5 || s > 7, q[1]);
         wr(8'h08, 32'h2);
      end
      rd(8'h40);
      cmp("unmapped", 32'h0, q);
      print_verdict();
   end
endmodule
`default_nettype wire
